/* File: hw/plsr_cfg.svh */
// Constants of the link status and receive block
`ifndef PLSR_CFG_SVH
`define PLSR_CFG_SVH
`define PLSR_CTL_IDLE 2'h0
`define PLSR_CTL_STATUS 2'h1
`define PLSR_CTL_RECEIVE 2'h2
`define PLSR_DATA_ON 8'hFF
`define PLSR_TYPE_NONE 3'h0
`define PLSR_TYPE_INTR 3'h1
`define PLSR_TYPE_REG_SOL 3'h2
`define PLSR_TYPE_REG_UNSOL 3'h3
`define PLSR_TYPE_RESTORE 3'h4
`define PLSR_TYPE_RESTORE_RST 3'h5
`define PLSR_TYPE_ERROR 3'h6
`define PLSR_SHORT_LEN 5'h05
`define PLSR_LONG_LEN 5'h11
`define PLSR_REG0_ADDR 4'h0
`define PLSR_FIFO_DEPTH 16
`endif

/* File: hw/plsr_pkg.sv */
// Types of the link status and receive block
package plsr_pkg;
	typedef enum logic [3:0]
	{
		PLSR_RX_IDLE = 4'h1,
		PLSR_RX_DATAON = 4'h2,
		PLSR_RX_PACKET = 4'h4,
		PLSR_RX_GAP = 4'h8
	} plsr_rx_state_t;
endpackage

/* File: hw/plsr_fifo_if.sv */
// Handshake bundle between the receive FIFO and its users
`timescale 1ns/10ps
`default_nettype none
interface plsr_fifo_if #(parameter int WIDTH = 9);
	logic inValid;
	logic inReady;
	logic [WIDTH-1:0] inData;
	logic outValid;
	logic outReady;
	logic [WIDTH-1:0] outData;
	modport fifo (input inValid, output inReady, input inData, output outValid, input outReady, output outData);
	modport user (output inValid, input inReady, output inData, input outValid, output outReady, input outData);
endinterface
`default_nettype wire

/* File: hw/plsr_fifo.sv */
// Synchronous FIFO for received packet symbols
`timescale 1ns/10ps
`default_nettype none
module plsr_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
)
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	plsr_fifo_if.fifo port
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_reg;
	logic [AW-1:0] rdPtr_reg;
	logic [AW:0] count_reg;
	logic doWrite;
	logic doRead;

	assign port.inReady = (count_reg != (AW+1)'(DEPTH));
	assign port.outValid = (count_reg != '0);
	assign port.outData = mem[rdPtr_reg];
	assign doWrite = port.inValid && port.inReady;
	assign doRead = port.outValid && port.outReady;

	always_ff @(posedge ref_clk)
	begin
		if (doWrite)
			mem[wrPtr_reg] <= port.inData;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (doWrite)
				wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
			if (doRead)
				rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
			if (doWrite && !doRead)
				count_reg <= count_reg + 1'b1;
			else if (doRead && !doWrite)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: hw/plsr_status_tx.sv */
// Serial status transmitter with event arbitration
`include "plsr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module plsr_status_tx
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic interruptEvent,
	input wire logic illegalRequest,
	input wire logic interfaceRestored,
	input wire logic busResetWhileInactive,
	input wire logic regReadRequest,
	input wire logic [3:0] regReadAddr,
	input wire logic [7:0] regReadData,
	input wire logic busInitReport,
	input wire logic [7:0] reg0Data,
	output logic statusSerialLine,
	output logic statusBusy
);
	logic intrPend_reg;
	logic errPend_reg;
	logic restPend_reg;
	logic restRst_reg;
	logic solPend_reg;
	logic unsolPend_reg;
	logic [3:0] solAddr_reg;
	logic [7:0] solData_reg;
	logic [7:0] unsolData_reg;
	logic [16:0] shift_reg;
	logic [4:0] left_reg;
	logic [16:0] frame_next;
	logic [4:0] len_next;
	logic [5:0] pick;
	logic idleNow;

	// Short frame: stop zero above type above start one, sent LSB first
	function automatic logic [16:0] shortFrame(input logic [2:0] kind);
		shortFrame = {12'h000, 1'b0, kind[0], kind[1], kind[2], 1'b1};
	endfunction

	function automatic logic [16:0] regFrame(input logic [2:0] kind, input logic [3:0] addr, input logic [7:0] data);
		regFrame = {1'b0, 8'({<<{data}}), 4'({<<{addr}}), kind[0], kind[1], kind[2], 1'b1};
	endfunction

	assign idleNow = (left_reg == 5'h00);
	assign statusBusy = !idleNow;
	// Fixed priority; the reserved type has no source at all
	assign pick[0] = restPend_reg;
	assign pick[1] = !pick[0] && unsolPend_reg;
	assign pick[2] = !(|pick[1:0]) && solPend_reg;
	assign pick[3] = !(|pick[2:0]) && errPend_reg;
	assign pick[4] = !(|pick[3:0]) && intrPend_reg;
	assign pick[5] = |pick[4:0];

	always_comb
	begin
		frame_next = '0;
		len_next = `PLSR_SHORT_LEN;
		if (pick[0])
			frame_next = shortFrame(restRst_reg ? `PLSR_TYPE_RESTORE_RST : `PLSR_TYPE_RESTORE);
		else if (pick[1])
		begin
			frame_next = regFrame(`PLSR_TYPE_REG_UNSOL, `PLSR_REG0_ADDR, unsolData_reg);
			len_next = `PLSR_LONG_LEN;
		end
		else if (pick[2])
		begin
			frame_next = regFrame(`PLSR_TYPE_REG_SOL, solAddr_reg, solData_reg);
			len_next = `PLSR_LONG_LEN;
		end
		else if (pick[3])
			frame_next = shortFrame(`PLSR_TYPE_ERROR);
		else if (pick[4])
			frame_next = shortFrame(`PLSR_TYPE_INTR);
	end

	// Pending flags: a new event in the launch cycle wins over the clear, except a register read, which is dropped
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			intrPend_reg <= 1'b0;
			errPend_reg <= 1'b0;
			restPend_reg <= 1'b0;
			restRst_reg <= 1'b0;
			solPend_reg <= 1'b0;
			unsolPend_reg <= 1'b0;
			solAddr_reg <= '0;
			solData_reg <= '0;
			unsolData_reg <= '0;
		end
		else
		begin
			if (interruptEvent)
				intrPend_reg <= 1'b1;
			else if (idleNow && pick[4])
				intrPend_reg <= 1'b0;
			if (illegalRequest)
				errPend_reg <= 1'b1;
			else if (idleNow && pick[3])
				errPend_reg <= 1'b0;
			if (interfaceRestored)
			begin
				restPend_reg <= 1'b1;
				restRst_reg <= busResetWhileInactive;
			end
			else if (idleNow && pick[0])
				restPend_reg <= 1'b0;
			// Further reads are ignored until the pending one has been launched
			if (regReadRequest && !solPend_reg)
			begin
				solPend_reg <= 1'b1;
				solAddr_reg <= regReadAddr;
				solData_reg <= regReadData;
			end
			else if (idleNow && pick[2])
				solPend_reg <= 1'b0;
			if (busInitReport)
			begin
				unsolPend_reg <= 1'b1;
				unsolData_reg <= reg0Data;
			end
			else if (idleNow && pick[1])
				unsolPend_reg <= 1'b0;
		end
	end

	// Shifter: line rests low, LSB first, next frame only after the stop bit
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			shift_reg <= '0;
			left_reg <= '0;
			statusSerialLine <= 1'b0;
		end
		else if (idleNow && pick[5])
		begin
			statusSerialLine <= frame_next[0];
			shift_reg <= frame_next >> 1;
			left_reg <= len_next;
		end
		else if (!idleNow)
		begin
			statusSerialLine <= (left_reg == 5'h01) ? 1'b0 : shift_reg[0];
			shift_reg <= shift_reg >> 1;
			left_reg <= left_reg - 5'h01;
		end
		else
			statusSerialLine <= 1'b0;
	end
endmodule
`default_nettype wire

/* File: hw/plsr_link_if.sv */
// Top: status line and receive path toward the link-layer controller
`include "plsr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module plsr_link_if #(
	parameter int FIFO_DEPTH = `PLSR_FIFO_DEPTH
)
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic interruptEvent,
	input wire logic illegalRequest,
	input wire logic interfaceRestored,
	input wire logic busResetWhileInactive,
	input wire logic regReadRequest,
	input wire logic [3:0] regReadAddr,
	input wire logic [7:0] regReadData,
	input wire logic busInitReport,
	input wire logic [7:0] reg0Data,
	input wire logic dataPrefix,
	input wire logic [7:0] rxSpeedCode,
	input wire logic rxSymbolValid,
	input wire logic [7:0] rxSymbol,
	input wire logic rxDataEnd,
	output logic rxReady,
	input wire logic busStatusValid,
	input wire logic [7:0] busStatusBits,
	output logic busStatusTaken,
	output logic statusSerialLine,
	output logic statusBusy,
	output logic [1:0] interfaceControlLines,
	output logic [7:0] interfaceDataLines
);
	plsr_pkg::plsr_rx_state_t rxState_reg;
	logic [7:0] speed_reg;
	logic speedSent_reg;
	logic endSeen_reg;
	logic dataOnSent_reg;
	logic statusUsed_reg;
	logic [1:0] ctl_next;
	logic [7:0] data_next;
	logic popSymbol;
	logic insertStatus;
	plsr_fifo_if #(.WIDTH(9)) fifoBus ();

	plsr_status_tx statusTx
	(
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.interruptEvent(interruptEvent),
		.illegalRequest(illegalRequest),
		.interfaceRestored(interfaceRestored),
		.busResetWhileInactive(busResetWhileInactive),
		.regReadRequest(regReadRequest),
		.regReadAddr(regReadAddr),
		.regReadData(regReadData),
		.busInitReport(busInitReport),
		.reg0Data(reg0Data),
		.statusSerialLine(statusSerialLine),
		.statusBusy(statusBusy)
	);

	plsr_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) rxFifo
	(
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.port(fifoBus.fifo)
	);

	// Every symbol, own self-ID included, enters the FIFO unfiltered unless the sequencer is in PLSR_RX_IDLE; bit 8 marks the end
	assign fifoBus.inValid = (rxSymbolValid || rxDataEnd) && (rxState_reg != plsr_pkg::PLSR_RX_IDLE);
	assign fifoBus.inData = {rxDataEnd, rxSymbol};
	assign rxReady = fifoBus.inReady && (rxState_reg != plsr_pkg::PLSR_RX_GAP);

	// One bus status cycle may replace a data-on cycle, once per packet
	assign insertStatus = busStatusValid && !statusUsed_reg && (rxState_reg == plsr_pkg::PLSR_RX_DATAON) && dataOnSent_reg;
	assign busStatusTaken = insertStatus;
	assign popSymbol = (rxState_reg == plsr_pkg::PLSR_RX_PACKET) && speedSent_reg && fifoBus.outValid;
	assign fifoBus.outReady = popSymbol || ((rxState_reg == plsr_pkg::PLSR_RX_DATAON) && !insertStatus && dataOnSent_reg && fifoBus.outValid && fifoBus.outData[8]);

	always_comb
	begin
		ctl_next = `PLSR_CTL_IDLE;
		data_next = 8'h00;
		unique case (rxState_reg)
			plsr_pkg::PLSR_RX_IDLE:
			begin
				if (dataPrefix)
				begin
					ctl_next = `PLSR_CTL_RECEIVE;
					data_next = `PLSR_DATA_ON;
				end
			end
			plsr_pkg::PLSR_RX_DATAON:
			begin
				if (insertStatus)
				begin
					ctl_next = `PLSR_CTL_STATUS;
					data_next = busStatusBits;
				end
				else if (dataOnSent_reg && fifoBus.outValid && fifoBus.outData[8])
					ctl_next = `PLSR_CTL_IDLE;
				else if (dataOnSent_reg && fifoBus.outValid)
				begin
					ctl_next = `PLSR_CTL_RECEIVE;
					data_next = speed_reg;
				end
				else
				begin
					ctl_next = `PLSR_CTL_RECEIVE;
					data_next = `PLSR_DATA_ON;
				end
			end
			plsr_pkg::PLSR_RX_PACKET:
			begin
				if (popSymbol && fifoBus.outData[8])
					ctl_next = `PLSR_CTL_IDLE;
				else if (popSymbol)
				begin
					ctl_next = `PLSR_CTL_RECEIVE;
					data_next = fifoBus.outData[7:0];
				end
				else
				begin
					// Underrun: hold receive, data lines kept from last symbol
					ctl_next = `PLSR_CTL_RECEIVE;
					data_next = interfaceDataLines;
				end
			end
			plsr_pkg::PLSR_RX_GAP:
				ctl_next = `PLSR_CTL_IDLE;
		endcase
	end

	// Receive sequencer
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			rxState_reg <= plsr_pkg::PLSR_RX_IDLE;
			speed_reg <= 8'h00;
			dataOnSent_reg <= 1'b0;
			statusUsed_reg <= 1'b0;
			speedSent_reg <= 1'b0;
		end
		else
		begin
			unique case (rxState_reg)
				plsr_pkg::PLSR_RX_IDLE:
				begin
					if (dataPrefix)
					begin
						rxState_reg <= plsr_pkg::PLSR_RX_DATAON;
						speed_reg <= rxSpeedCode;
						dataOnSent_reg <= 1'b1;
						statusUsed_reg <= 1'b0;
						speedSent_reg <= 1'b0;
					end
				end
				plsr_pkg::PLSR_RX_DATAON:
				begin
					if (insertStatus)
						statusUsed_reg <= 1'b1;
					else if (fifoBus.outValid && fifoBus.outData[8])
						rxState_reg <= plsr_pkg::PLSR_RX_GAP;
					else if (fifoBus.outValid)
					begin
						// Speed code cycle carries no packet symbol, so the FIFO head is not popped until the packet state
						rxState_reg <= plsr_pkg::PLSR_RX_PACKET;
						speedSent_reg <= 1'b1;
					end
				end
				plsr_pkg::PLSR_RX_PACKET:
				begin
					if (popSymbol && fifoBus.outData[8])
						rxState_reg <= plsr_pkg::PLSR_RX_GAP;
				end
				plsr_pkg::PLSR_RX_GAP:
					rxState_reg <= plsr_pkg::PLSR_RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			interfaceControlLines <= `PLSR_CTL_IDLE;
			interfaceDataLines <= 8'h00;
		end
		else
		begin
			interfaceControlLines <= ctl_next;
			interfaceDataLines <= data_next;
		end
	end
endmodule
`default_nettype wire

/* File: verification/plsr_link_if_properties.sv */
// Checker for the status line and receive path of the link interface top
`include "plsr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module plsr_link_if_properties
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [7:0] busStatusBits,
	input wire logic busStatusTaken,
	input wire logic statusSerialLine,
	input wire logic statusBusy,
	input wire logic [1:0] interfaceControlLines,
	input wire logic [7:0] interfaceDataLines
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	// Busy drops for one cycle between back-to-back frames, so every frame of a train is framed here
	sequence sStart;
		$rose(statusBusy) && statusSerialLine;
	endsequence
	sequence sShort;
		sStart ##1 statusSerialLine;
	endsequence
	sequence sLong;
		sStart ##1 !statusSerialLine ##1 statusSerialLine;
	endsequence
	a_line_rest: assert property (!statusBusy |-> !statusSerialLine)
		else $error("status line high at rest");
	a_start_bit: assert property ($rose(statusBusy) |-> statusSerialLine)
		else $error("frame began without start bit");
	a_short_stop: assert property (sShort |-> ##3 !statusSerialLine)
		else $error("short frame stop bit wrong");
	a_no_reserved: assert property (sShort ##1 statusSerialLine |=> !statusSerialLine)
		else $error("reserved type sent");
	a_long_stop: assert property (sLong |-> ##14 !statusSerialLine)
		else $error("register frame stop bit wrong");
	a_rx_dataon: assert property (interfaceControlLines == `PLSR_CTL_RECEIVE &&
		$past(interfaceControlLines) == `PLSR_CTL_IDLE |-> interfaceDataLines == `PLSR_DATA_ON)
		else $error("receive opened without data-on");
	a_rx_gap: assert property ($past(interfaceControlLines) == `PLSR_CTL_RECEIVE &&
		interfaceControlLines == `PLSR_CTL_IDLE |=> interfaceControlLines == `PLSR_CTL_IDLE)
		else $error("no idle gap after receive");
	a_status_once: assert property (interfaceControlLines == `PLSR_CTL_STATUS |=>
		interfaceControlLines == `PLSR_CTL_RECEIVE)
		else $error("status cycle longer than one clock");
	a_status_bits: assert property (busStatusTaken |=> interfaceControlLines == `PLSR_CTL_STATUS &&
		interfaceDataLines == $past(busStatusBits))
		else $error("bus status cycle wrong");
endmodule
bind plsr_link_if plsr_link_if_properties chk_u (.ref_clk, .sys_rst, .busStatusBits, .busStatusTaken,
	.statusSerialLine, .statusBusy, .interfaceControlLines, .interfaceDataLines);
`default_nettype wire

/* File: verification/plsr_link_model.sv */
// Link-side model: decodes status frames and receive traffic
`include "plsr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module plsr_link_model
(
	input wire logic ref_clk,
	input wire logic statusSerialLine,
	input wire logic [1:0] interfaceControlLines,
	input wire logic [7:0] interfaceDataLines
);
	logic [16:0] bits;
	logic [21:0] frames [$];
	logic [7:0] symbols [$];
	logic [7:0] speedSeen;
	logic [7:0] statusSeen;
	logic inRx = 1'h0;
	logic sawSpeed = 1'h0;
	int pos = 0;
	int dataOn = 0;
	int rxCount = 0;
	// Frames are queued with their length on top so short and long ones compare apart
	always @(posedge ref_clk)
	begin
		if (pos == 0 && statusSerialLine === 1'h1)
		begin
			bits = 17'h00001;
			pos = 1;
		end
		else if (pos > 0)
		begin
			bits[pos] = statusSerialLine;
			pos++;
			if ((pos == 5 && !(bits[2] && !bits[1])) || pos == 17)
			begin
				frames.push_back({5'(pos), bits});
				pos = 0;
			end
		end
	end
	always @(posedge ref_clk)
	begin
		if (interfaceControlLines === `PLSR_CTL_RECEIVE)
		begin
			if (!inRx)
			begin
				sawSpeed = 1'h0;
				dataOn = 0;
				symbols.delete();
			end
			inRx = 1'h1;
			if (sawSpeed)
				symbols.push_back(interfaceDataLines);
			else if (interfaceDataLines !== `PLSR_DATA_ON)
			begin
				sawSpeed = 1'h1;
				speedSeen = interfaceDataLines;
			end
			else
				dataOn++;
		end
		else if (interfaceControlLines === `PLSR_CTL_STATUS)
			statusSeen = interfaceDataLines;
		else if (inRx)
		begin
			inRx = 1'h0;
			rxCount++;
		end
	end
endmodule
`default_nettype wire

/* File: verification/plsr_link_if_tb.sv */
// Testbench of the link interface top: status frames and packet reception
`include "plsr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module plsr_link_if_tb;
	logic ref_clk = 1'h0, sys_rst = 1'h1, interruptEvent = 1'h0, illegalRequest = 1'h0;
	logic interfaceRestored = 1'h0, busResetWhileInactive = 1'h0, regReadRequest = 1'h0;
	logic busInitReport = 1'h0, dataPrefix = 1'h0, rxSymbolValid = 1'h0, rxDataEnd = 1'h0;
	logic busStatusValid = 1'h0;
	logic [3:0] regReadAddr = 4'h0;
	logic [7:0] regReadData = 8'h00, reg0Data = 8'h00, rxSpeedCode = 8'h00;
	logic [7:0] rxSymbol = 8'h00, busStatusBits = 8'h00;
	wire logic rxReady, busStatusTaken, statusSerialLine, statusBusy;
	wire logic [1:0] interfaceControlLines;
	wire logic [7:0] interfaceDataLines;
	int err_count = 0;
	int comparisons = 0;
	logic [7:0] spd [7] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0D};
	plsr_link_if dut_u (.ref_clk, .sys_rst, .interruptEvent, .illegalRequest, .interfaceRestored,
		.busResetWhileInactive, .regReadRequest, .regReadAddr, .regReadData, .busInitReport, .reg0Data,
		.dataPrefix, .rxSpeedCode, .rxSymbolValid, .rxSymbol, .rxDataEnd, .rxReady, .busStatusValid,
		.busStatusBits, .busStatusTaken, .statusSerialLine, .statusBusy, .interfaceControlLines,
		.interfaceDataLines);
	plsr_link_model lm (.ref_clk, .statusSerialLine, .interfaceControlLines, .interfaceDataLines);
	initial
	begin
		forever #4 ref_clk = ~ref_clk;
	end
	task report_and_stop;
		if (err_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task check(input logic [21:0] got, input logic [21:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task bound(input int k);
		if (k >= 80)
		begin
			err_count++;
			$display("[FAIL] %0t wait timed out", $time);
			report_and_stop();
		end
	endtask
	// Line order: type and fields go out most significant bit first
	function automatic logic [21:0] expf(input logic [2:0] t, input logic [3:0] a, input logic [7:0] d);
		logic [21:0] e;
		e = {5'h11, 17'h00001};
		for (int i = 0; i < 8; i++)
		begin
			if (i < 3)
				e[1 + i] = t[2 - i];
			if (i < 4)
				e[4 + i] = a[3 - i];
			e[8 + i] = d[7 - i];
		end
		if (t != 3'h2 && t != 3'h3)
			e[21:4] = {5'h05, 13'h0000};
		return e;
	endfunction
	task stat(input logic [2:0] t, input logic [3:0] a, input logic [7:0] d);
		int k;
		@(posedge ref_clk);
		interruptEvent <= (t == 3'h1);
		illegalRequest <= (t == 3'h6);
		regReadRequest <= (t == 3'h2);
		busInitReport <= (t == 3'h3);
		interfaceRestored <= t[2] && !t[1];
		busResetWhileInactive <= t[0];
		regReadAddr <= a;
		regReadData <= d;
		reg0Data <= d;
		@(posedge ref_clk);
		{interruptEvent, illegalRequest, regReadRequest, busInitReport, interfaceRestored} <= 5'h00;
		k = 0;
		while (lm.frames.size() == 0 && k < 80)
		begin
			@(negedge ref_clk);
			k++;
		end
		bound(k);
		check(lm.frames.pop_front(), expf(t, a, d));
	endtask
	// Error and interrupt together, interrupt repeated while queued: one frame of each
	task prio;
		int k;
		@(posedge ref_clk);
		interruptEvent <= 1'h1;
		illegalRequest <= 1'h1;
		@(posedge ref_clk);
		illegalRequest <= 1'h0;
		@(posedge ref_clk);
		interruptEvent <= 1'h0;
		k = 0;
		while (k < 40)
		begin
			@(negedge ref_clk);
			k++;
		end
		check(22'(lm.frames.size()), 22'h000002);
		check(lm.frames.pop_front(), expf(3'h6, 4'h0, 8'h00));
		check(lm.frames.pop_front(), expf(3'h1, 4'h0, 8'h00));
	endtask
	task put(input logic e, input logic [7:0] s);
		int k;
		rxSymbolValid <= !e;
		rxDataEnd <= e;
		rxSymbol <= s;
		k = 0;
		@(negedge ref_clk);
		while (rxReady !== 1'h1 && k < 80)
		begin
			@(negedge ref_clk);
			k++;
		end
		bound(k);
		@(posedge ref_clk);
	endtask
	task pkt(input logic [7:0] sp, input int n, input int dly, input logic [7:0] sb);
		int k;
		int c;
		c = lm.rxCount;
		@(posedge ref_clk);
		dataPrefix <= 1'h1;
		rxSpeedCode <= sp;
		busStatusValid <= (sb != 8'h00);
		busStatusBits <= sb;
		@(posedge ref_clk);
		dataPrefix <= 1'h0;
		repeat (dly) @(posedge ref_clk);
		busStatusValid <= 1'h0;
		busStatusBits <= ~sb;
		for (int i = 0; i < n; i++)
			put(1'h0, 8'hFD + 8'(i));
		put(1'h1, 8'h00);
		rxDataEnd <= 1'h0;
		rxSymbol <= 8'hFF;
		k = 0;
		while (lm.rxCount == c && k < 80)
		begin
			@(negedge ref_clk);
			k++;
		end
		bound(k);
		check(lm.sawSpeed, n > 0);
		if (n > 0)
			check(lm.speedSeen, sp);
		check(22'(lm.symbols.size()), 22'(n));
		for (int i = 0; i < n; i++)
			check(lm.symbols[i], 8'hFD + 8'(i));
		check(lm.dataOn > 0, 1'h1);
		if (sb != 8'h00)
			check(lm.statusSeen, sb);
	endtask
	initial
	begin
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'h0;
		for (int t = 1; t < 7; t++)
			stat(3'(t), (t == 2) ? 4'hA : 4'h0, 8'h5C);
		prio();
		foreach (spd[i])
			pkt(spd[i], 3, 0, 8'h00);
		pkt(8'h09, 0, 0, 8'h00);
		pkt(8'h08, 2, 4, 8'h40);
		check(22'(lm.frames.size()), 22'h000000);
		report_and_stop();
	end
endmodule
`default_nettype wire
